// *** ppo_pkg.sv ***
// Purpose: shared constants and types of the port power / overcurrent block
// Assumes: 125 MHz core clock, 4 downstream ports
// Notes:   register offsets are byte addresses on the plain register port
package ppo_pkg;

   // ---------------------------------------------------------------
   // geometry and timing
   // ---------------------------------------------------------------
   localparam int PORTS = 4;
   localparam int CLK_PERIOD_NS = 8;
   localparam int FAULT_FILTER_NS = 1000;   // least time a fault level holds
   localparam int FAULT_FILTER_CYC =
      (FAULT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_EVENT = 4'h8;
   localparam logic [3:0] ADDR_MASK = 4'hc;

   // control register fields
   localparam int CTRL_CFG_VALID = 0;       // stored mode overrides strap
   localparam int CTRL_CFG_GANGED = 1;
   localparam int CTRL_POL_OVERRIDE = 2;    // stored polarity overrides strap
   localparam int CTRL_POL_HIGH = 3;
   localparam int CTRL_SWAP_EN = 4;
   localparam int CTRL_REQ_LSB = 8;         // per-port power request, 4 bits
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // status register fields
   localparam int STAT_FAULT_LSB = 0;
   localparam int STAT_ON_LSB = 4;
   localparam int STAT_GANGED = 8;
   localparam int STAT_VBUS = 9;
   localparam int STAT_LOW_POWER = 10;
   localparam int STAT_SWAPPED = 11;
   localparam int STAT_CONN_LSB = 12;
   localparam int STAT_POL_HIGH = 14;

   // event / mask registers: bits 3:0 fault change, bit 4 vbus change
   localparam int EVT_WIDTH = 5;
   localparam int EVT_VBUS = 4;
   localparam logic [EVT_WIDTH-1:0] MASK_RESET = 5'h00;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0] powerReq;
      logic swapEnable;
      logic polHigh;
      logic polOverride;
      logic cfgGanged;
      logic cfgValid;
   } ppo_cfg_t;

   typedef enum logic [1:0] {
      PORT_OFF = 2'b00,
      PORT_ON = 2'b01,
      PORT_TRIPPED = 2'b10
   } ppo_port_state_t;

endpackage

// *** ppo_port_ctrl.sv ***
// Purpose: one downstream port: fault filter and power state
// Assumes: fault input synchronous to clk, low means overcurrent
// Notes:   a trip holds power off until the request is withdrawn
`timescale 1ns/1ns
module ppo_port_ctrl
   import ppo_pkg::*;
#(
   parameter int FILTER_CYC = FAULT_FILTER_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // port control
   input wire logic fault_n,
   input wire logic powerReq,
   input wire logic lowPower,
   // port state
   output logic powerOn,
   output logic faultLed,
   output logic faultLevel,
   output logic faultChange
);

   // ---------------------------------------------------------------
   // fault filter
   // ---------------------------------------------------------------
   logic [7:0] filtCnt;
   ppo_port_state_t state;
   ppo_port_state_t next_state;

   // level must stand FILTER_CYC cycles, so switch-start glitches pass by
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         filtCnt <= 8'h00;
         faultLevel <= 1'b0;
      end else if ((!fault_n) == faultLevel) begin
         filtCnt <= 8'h00;
      end else if (filtCnt == 8'(FILTER_CYC - 1)) begin
         filtCnt <= 8'h00;
         faultLevel <= !fault_n;
      end else begin
         filtCnt <= filtCnt + 8'h01;
      end
   end

   // one-cycle pulse on each filtered change, reported to the host
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         faultChange <= 1'b0;
      end else begin
         faultChange <= (filtCnt == 8'(FILTER_CYC - 1))
            && ((!fault_n) != faultLevel);
      end
   end

   // ---------------------------------------------------------------
   // power state
   // ---------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         PORT_OFF: begin
            if (powerReq && !lowPower && !faultLevel) begin
               next_state = PORT_ON;
            end
         end
         PORT_ON: begin
            if (faultLevel) begin
               next_state = PORT_TRIPPED;
            end else if (!powerReq || lowPower) begin
               next_state = PORT_OFF;
            end
         end
         PORT_TRIPPED: begin
            if (!powerReq) begin
               next_state = PORT_OFF;
            end
         end
         default: begin
            next_state = PORT_OFF;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= PORT_OFF;
      end else begin
         state <= next_state;
      end
   end

   assign powerOn = (state == PORT_ON);
   assign faultLed = (state == PORT_TRIPPED) || faultLevel;

   // a trip shuts the port within one edge
   property p_trip_off;
      @(posedge clk) disable iff (!rst_n)
      (state == PORT_ON) && faultLevel |=> !powerOn && faultLed;
   endproperty
   a_trip_off: assert property (p_trip_off)
      else $error("port stayed powered after a fault");

endmodule // ppo_port_ctrl

// *** ppo_power_ctrl.sv ***
// Purpose: downstream port power control and overcurrent detection
// Assumes: all pins synchronous to clk; pad pull-ups live in the pad ring
// Notes:   straps are caught while rst_n is low, one capture per cycle
//
// How it works
// - a low level on a port fault input means overcurrent on that port.
// - the ganging strap is caught during reset, high or open means ganged.
// - a low chip enable puts the block in low power with all ports off.
// - with swapping enabled, a low swap input exchanges upstream and port 1.
// - reset is active low, so a pulled-up open input keeps the block running.
// - each of the four ports has a fault lamp lit while the port is abnormal.
// - lamps 3 and 4 are read as the connector mode strap during reset.
// - ganged mode uses the port 1 fault input for all ports.
// - ganged mode drives only the port 1 enable, switching all ports.
// - enable polarity comes from a strap or from stored configuration.
// - fault inputs have weak pull-ups, so an open input reads no fault.
// - a divided upstream supply level shows whether bus power is present.
// - by default an enable is driven low to power the port.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
module ppo_power_ctrl
   import ppo_pkg::*;
#(
   parameter int FILTER_CYC = FAULT_FILTER_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   output logic irq,
   // fault inputs from the power switches
   input wire logic port1_fault_n,
   input wire logic port2_fault_n,
   input wire logic port3_fault_n,
   input wire logic port4_fault_n,
   // power enables to the power switches
   output logic port1_power_on_n,
   output logic port2_power_on_n,
   output logic port3_power_on_n,
   output logic port4_power_on_n,
   // fault lamps; 3 and 4 double as the connector mode strap
   output logic port1_fault_led,
   output logic port2_fault_led,
   output logic port3_fault_led,
   output logic port3_fault_led_oe,
   input wire logic conn_mode_strap0,
   output logic port4_fault_led,
   output logic port4_fault_led_oe,
   input wire logic conn_mode_strap1,
   // straps and system pins
   input wire logic ganged_mode_strap,
   input wire logic enable_polarity_strap,
   input wire logic upstream_power_sense,
   input wire logic chipEnable,
   input wire logic swapControl_n,
   // system state
   output logic lowPower,
   output logic portSwap,
   output logic [1:0] connMode
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   ppo_cfg_t cfg;
   logic [EVT_WIDTH-1:0] event_q;
   logic [EVT_WIDTH-1:0] mask;
   logic [EVT_WIDTH-1:0] next_event;
   logic [EVT_WIDTH-1:0] evtSet;
   logic gangStrap;
   logic polStrap;
   logic ganged;
   logic polHigh;
   logic vbusPresent;
   logic vbusLast;
   logic [PORTS-1:0] faultPins_n;
   logic [PORTS-1:0] portOn;
   logic [PORTS-1:0] portLed;
   logic [PORTS-1:0] portFault;
   logic [PORTS-1:0] portChange;
   logic [PORTS-1:0] pinOn;
   logic [PORTS-1:0] pinLevel;
   logic [PORTS-1:0] ledQ;
   logic evtRead;

   // ---------------------------------------------------------------
   // straps
   // ---------------------------------------------------------------
   // caught on every edge while reset is low, last value held after release;
   // open pins read high through the pad pull-ups
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gangStrap <= ganged_mode_strap;
         polStrap <= enable_polarity_strap;
         connMode <= {conn_mode_strap1, conn_mode_strap0};
      end
   end

   // lamps 3 and 4 float during reset so the strap resistors can be read
   assign port3_fault_led_oe = rst_n;
   assign port4_fault_led_oe = rst_n;

   // stored configuration outranks the strap level
   assign ganged = cfg.cfgValid ? cfg.cfgGanged : gangStrap;
   // strap low selects the default, low-true enables
   assign polHigh = cfg.polOverride ? cfg.polHigh : polStrap;

   // ---------------------------------------------------------------
   // system pins
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lowPower <= 1'b1;
         portSwap <= 1'b0;
         vbusPresent <= 1'b0;
         vbusLast <= 1'b0;
      end else begin
         lowPower <= !chipEnable;
         portSwap <= cfg.swapEnable && !swapControl_n;
         vbusPresent <= upstream_power_sense;
         vbusLast <= vbusPresent;
      end
   end

   // ---------------------------------------------------------------
   // per-port control
   // ---------------------------------------------------------------
   // open fault inputs read high through weak pull-ups: no fault
   assign faultPins_n = {port4_fault_n, port3_fault_n,
                         port2_fault_n, port1_fault_n};

   generate
      for (genvar i = 0; i < PORTS; i++) begin : g_port
         // ganged: one shared input and one request cover every port
         ppo_port_ctrl #(
            .FILTER_CYC(FILTER_CYC)
         ) u_port (
            .clk(clk),
            .rst_n(rst_n),
            .fault_n(ganged ? faultPins_n[0] : faultPins_n[i]),
            .powerReq(ganged ? cfg.powerReq[0] : cfg.powerReq[i]),
            .lowPower(lowPower),
            .powerOn(portOn[i]),
            .faultLed(portLed[i]),
            .faultLevel(portFault[i]),
            .faultChange(portChange[i])
         );
         // ganged mode leaves enables 2..4 idle; port 1 switches all
         assign pinOn[i] = (ganged && i != 0) ? 1'b0 : portOn[i];
         // only the shared port reports in ganged mode
         assign evtSet[i] = portChange[i] && (!ganged || i == 0);
      end
   endgenerate
   assign evtSet[EVT_VBUS] = vbusPresent != vbusLast;

   // enables and lamps from flops; default drives low to switch power on
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pinLevel <= 4'hf;
         ledQ <= 4'h0;
      end else begin
         pinLevel <= polHigh ? pinOn : ~pinOn;
         ledQ <= portLed;
      end
   end

   assign port1_power_on_n = pinLevel[0];
   assign port2_power_on_n = pinLevel[1];
   assign port3_power_on_n = pinLevel[2];
   assign port4_power_on_n = pinLevel[3];
   assign port1_fault_led = ledQ[0];
   assign port2_fault_led = ledQ[1];
   assign port3_fault_led = ledQ[2];
   assign port4_fault_led = ledQ[3];

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // configuration and mask writes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg <= ppo_cfg_t'(CTRL_RESET[8:0]);
         mask <= MASK_RESET;
      end else if (regWrite && regAddr == ADDR_CTRL) begin
         cfg.cfgValid <= regWdata[CTRL_CFG_VALID];
         cfg.cfgGanged <= regWdata[CTRL_CFG_GANGED];
         cfg.polOverride <= regWdata[CTRL_POL_OVERRIDE];
         cfg.polHigh <= regWdata[CTRL_POL_HIGH];
         cfg.swapEnable <= regWdata[CTRL_SWAP_EN];
         cfg.powerReq <= regWdata[CTRL_REQ_LSB +: 4];
      end else if (regWrite && regAddr == ADDR_MASK) begin
         mask <= regWdata[EVT_WIDTH-1:0];
      end
   end

   // sticky events: a read clears them, a new event in that cycle survives
   assign evtRead = regRead && regAddr == ADDR_EVENT;
   assign next_event = (evtRead ? '0 : event_q) | evtSet;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         event_q <= '0;
      end else begin
         event_q <= next_event;
      end
   end

   assign irq = |(event_q & mask);

   // read data for one cycle after the strobe, zero otherwise
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         regRdata <= 32'h0000_0000;
      end else if (!regRead) begin
         regRdata <= 32'h0000_0000;
      end else begin
         case (regAddr)
            ADDR_CTRL: begin
               regRdata <= {20'h00000, cfg.powerReq, 3'h0, cfg.swapEnable,
                  cfg.polHigh, cfg.polOverride, cfg.cfgGanged,
                  cfg.cfgValid};
            end
            ADDR_STATUS: begin
               regRdata <= {17'h0, polHigh, connMode, portSwap,
                  lowPower, vbusPresent, ganged, pinOn, portFault};
            end
            ADDR_EVENT: begin
               regRdata <= {27'h0, event_q};
            end
            ADDR_MASK: begin
               regRdata <= {27'h0, mask};
            end
            default: begin
               regRdata <= 32'h0000_0000;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_low_power_off;
      @(posedge clk) disable iff (!rst_n)
      !chipEnable [*3] |-> lowPower && portOn == 4'h0;
   endproperty
   a_low_power_off: assert property (p_low_power_off)
      else $error("port powered while chip disabled");

   property p_gang_idle;
      @(posedge clk) disable iff (!rst_n)
      $past(rst_n) && ganged && $past(ganged) |->
         pinLevel[3:1] == {3{$past(!polHigh)}};
   endproperty
   a_gang_idle: assert property (p_gang_idle)
      else $error("secondary enable driven in ganged mode");

   property p_polarity;
      @(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> pinLevel[0] == ($past(pinOn[0]) ~^ $past(polHigh));
   endproperty
   a_polarity: assert property (p_polarity)
      else $error("port 1 enable level wrong for polarity");

   property p_default_low;
      @(posedge clk) disable iff (!rst_n)
      !cfg.polOverride && !polStrap && portOn[1] && !ganged
         |=> !port2_power_on_n;
   endproperty
   a_default_low: assert property (p_default_low)
      else $error("default polarity did not drive low for power");

   property p_conn_strap;
      @(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> connMode == $past({conn_mode_strap1,
         conn_mode_strap0}) && port3_fault_led_oe;
   endproperty
   a_conn_strap: assert property (p_conn_strap)
      else $error("connector mode strap not caught at reset");

   property p_swap;
      @(posedge clk) disable iff (!rst_n)
      cfg.swapEnable && !swapControl_n |=> portSwap;
   endproperty
   a_swap: assert property (p_swap)
      else $error("swap request not followed");

   property p_mode_pick;
      @(posedge clk) disable iff (!rst_n)
      cfg.cfgValid |-> ganged == cfg.cfgGanged;
   endproperty
   a_mode_pick: assert property (p_mode_pick)
      else $error("strap overrode stored mode");

   property p_vbus_event;
      @(posedge clk) disable iff (!rst_n)
      $changed(vbusPresent) |=> event_q[EVT_VBUS];
   endproperty
   a_vbus_event: assert property (p_vbus_event)
      else $error("upstream power change not reported");

   property p_shared_fault;
      @(posedge clk) disable iff (!rst_n)
      ganged && $past(ganged) && portFault[0] |-> portFault == 4'hf;
   endproperty
   a_shared_fault: assert property (p_shared_fault)
      else $error("shared fault not applied to all ports");

   property p_lamp;
      @(posedge clk) disable iff (!rst_n)
      portFault[2] |=> port3_fault_led;
   endproperty
   a_lamp: assert property (p_lamp)
      else $error("fault lamp dark during fault");

   property p_fault_active_low;
      @(posedge clk) disable iff (!rst_n)
      !$past(ganged) && $rose(portFault[1]) |-> $past(!port2_fault_n);
   endproperty
   a_fault_active_low: assert property (p_fault_active_low)
      else $error("port 2 fault level rose without a low input");

endmodule // ppo_power_ctrl

// *** ppo_switch_model.sv ***
// Purpose: behavioural model of the external current-limited power switches
// Assumes: one switch per port, or one switch for all ports when ganged
// Notes:   flags are open drain; the weak pull-up reads high when released
`timescale 1ns/1ns
module ppo_switch_model (
   // fault requests from the bench
   input wire logic [3:0] tripCmd,
   // enable pins from the hub and their active level
   input wire logic [3:0] powerOn_n,
   input wire logic polHigh,
   input wire logic ganged,
   // flags towards the hub and supplies towards the connectors
   output logic [3:0] flag_n,
   output logic [3:0] supplyOn
);
   // ------------------------------------------------------------
   // flags and supplies
   // ------------------------------------------------------------
   logic [3:0] enabled;

   // a released flag floats up to the pull-up, never to a stale low
   assign flag_n = ~tripCmd;
   // enable level decoded with the polarity the hub was given
   assign enabled = polHigh ? powerOn_n : ~powerOn_n;
   // one shared switch feeds every connector in ganged wiring
   always_comb begin
      if (ganged) begin
         supplyOn = {4{enabled[0] & ~tripCmd[0]}};
      end else begin
         supplyOn = enabled & ~tripCmd;
      end
   end
endmodule // ppo_switch_model

// *** tb_ppo_power_ctrl.sv ***
// Purpose: self-checking bench for the port power / overcurrent block
// Assumes: fault filter shortened to FILT cycles for a quick run
// Notes:   random requests and trip ports come from a fixed seed
`timescale 1ns/1ns
module tb_ppo_power_ctrl import ppo_pkg::*;;
   localparam int FILT = 4;
   logic clk, rst_n, regWrite, regRead, irq, gangStrap, sense, chipEnable;
   logic swapControl_n, lowPower, portSwap, modelPol, modelGang, polPin;
   logic [3:0] regAddr, pins, lamps, flag_n, supply, trip, req;
   logic [31:0] regWdata, regRdata;
   logic [1:0] conn, connPin, connMode, ledOe;
   int p, errors, compares;
   int cycles = 0;

   ppo_power_ctrl #(.FILTER_CYC(FILT)) ppo_power_ctrl_inst (
      .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .irq(irq), .port1_fault_n(flag_n[0]), .port2_fault_n(flag_n[1]),
      .port3_fault_n(flag_n[2]), .port4_fault_n(flag_n[3]),
      .port1_power_on_n(pins[0]), .port2_power_on_n(pins[1]),
      .port3_power_on_n(pins[2]), .port4_power_on_n(pins[3]),
      .port1_fault_led(lamps[0]), .port2_fault_led(lamps[1]),
      .port3_fault_led(lamps[2]), .port3_fault_led_oe(ledOe[0]),
      .conn_mode_strap0(connPin[0]), .port4_fault_led(lamps[3]),
      .port4_fault_led_oe(ledOe[1]), .conn_mode_strap1(connPin[1]),
      .ganged_mode_strap(gangStrap), .enable_polarity_strap(polPin),
      .upstream_power_sense(sense), .chipEnable(chipEnable),
      .swapControl_n(swapControl_n), .lowPower(lowPower),
      .portSwap(portSwap), .connMode(connMode));

   ppo_switch_model ppo_switch_model_inst (
      .tripCmd(trip), .powerOn_n(pins), .polHigh(modelPol),
      .ganged(modelGang), .flag_n(flag_n), .supplyOn(supply));

   // ------------------------------------------------------------
   // clock, timeout and helpers
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // whole run is well under a thousand cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors = errors + 1;
         close_out();
      end
   end

   // expected enable pins; ganged wiring uses only the port 1 pin
   function automatic logic [3:0] expPins(input logic [3:0] on,
                                          input logic hi, input logic g);
      logic [3:0] act;
      act = g ? {3'b000, on[0]} : on;
      return hi ? act : ~act;
   endfunction

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      compares = compares + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [31:0] exp,
                     input string what);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      chk(what, exp, regRdata);
   endtask

   // drive a fault on the given ports, let the filter and trip settle
   task automatic fault(input logic [3:0] ports);
      @(posedge clk);
      trip <= ports;
      tick(FILT + 4);
   endtask

   task automatic close_out();
      if (errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      errors = 0;
      compares = 0;
      void'($urandom(12536));
      conn = 2'($urandom);
      {rst_n, regWrite, regRead, gangStrap, modelPol, modelGang} = 6'h0;
      {sense, chipEnable, swapControl_n} = 3'b111;
      {regAddr, trip, regWdata} = 40'h0;
      polPin = 1'b0;
      connPin = conn;
      repeat (2) @(posedge clk);
      #1;
      chk("pins in reset", 32'hf, 32'(pins));
      chk("lamps in reset", 32'h0, 32'(lamps));
      chk("lamp oe in reset", 32'h0, 32'(ledOe));
      chk("low power in reset", 32'h1, 32'(lowPower));
      @(posedge clk);
      rst_n <= 1'b1;
      gangStrap <= 1'b1; // moving straps after reset must not count
      connPin <= ~conn;
      tick(2);
      chk("lamp oe", 32'h3, 32'(ledOe));
      chk("conn mode", 32'(conn), 32'(connMode));
      rd(ADDR_CTRL, 32'h0, "ctrl reset");
      rd(ADDR_MASK, 32'h0, "mask reset");
      rd(4'h1, 32'h0, "unmapped");
      rd(ADDR_STATUS, {18'h0, conn, 4'h2, 8'h0}, "status");
      // upstream power rising out of reset is itself a change
      rd(ADDR_EVENT, 32'h10, "vbus up");
      wr(ADDR_MASK, 32'h1f);
      // random requests, one port tripped each round
      for (int i = 0; i < 4; i++) begin
         p = (i == 0) ? 3 : (i == 1) ? 1 : int'($urandom_range(3));
         req = 4'($urandom) | (4'h1 << p);
         wr(ADDR_CTRL, {20'h0, req, 8'h0});
         tick(3);
         chk("pins on", 32'(expPins(req, 0, 0)), 32'(pins));
         fault(4'h1 << p);
         req = req & ~(4'h1 << p);
         chk("pins trip", 32'(expPins(req, 0, 0)), 32'(pins));
         chk("lamps", 32'(4'h1 << p), 32'(lamps));
         chk("irq", 32'h1, 32'(irq));
         fault(4'h0);
         chk("trip holds", 32'(expPins(req, 0, 0)), 32'(pins));
         rd(ADDR_EVENT, 32'h1 << p, "event");
         chk("irq clear", 32'h0, 32'(irq));
         wr(ADDR_CTRL, 32'h0);
      end
      // stored polarity, enables active high
      modelPol <= 1'b1;
      wr(ADDR_CTRL, 32'h50c);
      tick(3);
      chk("pins high pol", 32'(expPins(4'h5, 1, 0)), 32'(pins));
      chk("supply high pol", 32'h5, 32'(supply));
      // stored ganged mode over an independent strap
      modelPol <= 1'b0;
      modelGang <= 1'b1;
      wr(ADDR_CTRL, 32'h103);
      tick(3);
      chk("ganged pins", 32'(expPins(4'h1, 0, 1)), 32'(pins));
      chk("ganged supply", 32'hf, 32'(supply));
      fault(4'h1);
      chk("ganged trip", 32'hf, 32'(pins));
      chk("ganged lamps", 32'hf, 32'(lamps));
      fault(4'h0);
      rd(ADDR_EVENT, 32'h1, "ganged event");
      // chip enable low turns every port off; clear the trip first
      modelGang <= 1'b0;
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_CTRL, 32'hf00);
      tick(3);
      chk("pins awake", 32'h0, 32'(pins));
      chipEnable <= 1'b0;
      tick(4);
      chk("low power", 32'h1, 32'(lowPower));
      chk("low power pins", 32'hf, 32'(pins));
      chipEnable <= 1'b1;
      tick(3);
      chk("awake", 32'h0, 32'(lowPower));
      // swap input only counts while swapping is enabled
      swapControl_n <= 1'b0;
      wr(ADDR_CTRL, 32'h0);
      tick(3);
      chk("swap off", 32'h0, 32'(portSwap));
      wr(ADDR_CTRL, 32'h10);
      tick(3);
      chk("swap on", 32'h1, 32'(portSwap));
      swapControl_n <= 1'b1;
      tick(3);
      chk("swap released", 32'h0, 32'(portSwap));
      // upstream supply lost
      sense <= 1'b0;
      tick(3);
      rd(ADDR_EVENT, 32'h10, "vbus event");
      // second reset with the ganging and polarity straps high
      @(posedge clk);
      rst_n <= 1'b0;
      polPin <= 1'b1;
      conn = 2'($urandom);
      connPin <= conn;
      tick(3);
      @(posedge clk);
      rst_n <= 1'b1;
      polPin <= 1'b0;
      connPin <= ~conn;
      tick(2);
      rd(ADDR_STATUS, {17'h0, 1'b1, conn, 4'h1, 8'h0}, "status 2");
      wr(ADDR_CTRL, 32'h100);
      tick(3);
      chk("strap ganged", 32'(expPins(4'h1, 1, 1)), 32'(pins));
      wr(ADDR_CTRL, 32'h301);
      tick(3);
      chk("stored indep", 32'(expPins(4'h3, 1, 0)), 32'(pins));
      close_out();
   end
endmodule // tb_ppo_power_ctrl
